// ---- design/pps_pkg.sv ----
// pps_pkg: shared constants and types for the player power sequencer
package pps_pkg;
	// ============================================================
	// timing
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned I2C_HZ = 100_000;
	// quarter bit period of the i2c serial clock, in system clocks
	localparam int unsigned I2C_QTR_CYC = CLK_HZ / (I2C_HZ * 4);
	// supply-good must hold this long before power counts as stable
	localparam int unsigned STABLE_US = 10_000;
	localparam int unsigned STABLE_CYC = (CLK_HZ / 1_000_000) * STABLE_US;
	// length of the self-generated power-up reset
	localparam int unsigned POR_CYC = 16;
	// ============================================================
	// dac i2c addressing and register contents (plain defaults)
	localparam logic [6:0] DAC_ADDR = 7'h4d;
	localparam logic [7:0] DAC_FMT_SUBADDR = 8'h01;
	localparam logic [7:0] DAC_FMT_VALUE = 8'h00;
	localparam logic [7:0] DAC_GEN_CFG_SUBADDR = 8'h02;
	localparam logic [7:0] DAC_GEN_CFG_BASE = 8'h00;
	localparam int unsigned DAC_PWR_DOWN_BIT = 4;
	// ============================================================
	// sequencer states, gray along the on/off path
	typedef enum logic [2:0] {
		PPS_POR = 3'b000,
		PPS_WAIT_PWR = 3'b001,
		PPS_CFG_DAC = 3'b011,
		PPS_RUN = 3'b010,
		PPS_DEC_OFF = 3'b110,
		PPS_DAC_LOW = 3'b111,
		PPS_CUT_PWR = 3'b101,
		PPS_OFF = 3'b100
	} pps_state_t;
endpackage

// ---- design/pps_i2c_if.sv ----
// pps_i2c_if: request/answer carrier between sequencer and i2c master
`timescale 1ns/1ps
interface pps_i2c_if;
	logic req;
	logic [7:0] subaddr;
	logic [7:0] data;
	logic busy;
	logic done;
	logic nack;
	modport ctrl (output req, output subaddr, output data, input busy, input done, input nack);
	modport master (input req, input subaddr, input data, output busy, output done, output nack);
endinterface

// ---- design/pps_i2c_master.sv ----
// pps_i2c_master: sole-master i2c writer of one sub-address and one byte
`timescale 1ns/1ps
module pps_i2c_master (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	pps_i2c_if.master rq,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_out,
	output logic sda_oe_out
);
	// ============================================================
	// quarter-bit tick divider
	logic [15:0] div_reg;
	wire tick = (div_reg == 16'(pps_pkg::I2C_QTR_CYC - 1));
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || tick) div_reg <= '0;
		else div_reg <= div_reg + 16'h0001;
	end

	// ============================================================
	// synchronise sda for the ack sample; scl is never read back
	logic [1:0] sda_sync_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) sda_sync_reg <= 2'b11;
		else sda_sync_reg <= {sda_sync_reg[0], sda_in};
	end
	// scl_in stays unread: no clock stretching, sole master and fast slaves

	// ============================================================
	// frame: start, 3 bytes of 9 bits, stop; phase counts quarter bits
	logic active_reg;
	logic [26:0] shift_reg;
	logic [4:0] bit_reg;
	logic [1:0] phase_reg;
	logic [1:0] edge_reg; // 0 start, 1 data, 2 stop
	logic nack_reg;
	logic done_reg;
	logic scl_low_reg;
	logic sda_low_reg;
	wire [26:0] frame = {pps_pkg::DAC_ADDR, 1'b0, 1'b1, rq.subaddr, 1'b1, rq.data, 1'b1};
	wire last_bit = (bit_reg == 5'h1a);
	wire ack_slot = (bit_reg == 5'h08) || (bit_reg == 5'h11) || last_bit;

	// request starts a transfer; no arbitration or target logic
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			active_reg <= 1'b0;
			shift_reg <= '0;
			bit_reg <= '0;
			phase_reg <= '0;
			edge_reg <= '0;
			nack_reg <= 1'b0;
			done_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (!active_reg) begin
				if (rq.req) begin
					active_reg <= 1'b1;
					shift_reg <= frame;
					bit_reg <= '0;
					phase_reg <= '0;
					edge_reg <= 2'h0;
					nack_reg <= 1'b0;
				end
			end else if (tick) begin
				phase_reg <= phase_reg + 2'h1;
				case (edge_reg)
					2'h0: begin // start: sda falls while scl high
						if (phase_reg == 2'h1) sda_low_reg <= 1'b1;
						if (phase_reg == 2'h3) begin
							scl_low_reg <= 1'b1;
							edge_reg <= 2'h1;
						end
					end
					2'h1: begin
						if (phase_reg == 2'h0) sda_low_reg <= ~shift_reg[26];
						if (phase_reg == 2'h1) scl_low_reg <= 1'b0;
						if (phase_reg == 2'h2 && ack_slot && sda_sync_reg[1]) nack_reg <= 1'b1;
						if (phase_reg == 2'h3) begin
							scl_low_reg <= 1'b1;
							shift_reg <= {shift_reg[25:0], 1'b1};
							bit_reg <= bit_reg + 5'h01;
							if (last_bit) edge_reg <= 2'h2;
						end
					end
					2'h2: begin // stop: sda rises while scl high
						if (phase_reg == 2'h0) sda_low_reg <= 1'b1;
						if (phase_reg == 2'h1) scl_low_reg <= 1'b0;
						if (phase_reg == 2'h3) begin
							sda_low_reg <= 1'b0;
							active_reg <= 1'b0;
							done_reg <= 1'b1;
						end
					end
					default: edge_reg <= 2'h0;
				endcase
			end
		end
	end

	// open drain: enable means pulling the line low
	assign scl_oe_out = scl_low_reg;
	assign sda_oe_out = sda_low_reg;
	assign rq.busy = active_reg;
	assign rq.done = done_reg;
	assign rq.nack = nack_reg;
endmodule

// ---- design/pps_sequencer.sv ----
// pps_sequencer: power-on and power-off sequencing of decoder and dac
`timescale 1ns/1ps
module pps_sequencer #(
	parameter int unsigned STABLE_CYC = pps_pkg::STABLE_CYC
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic on_switch_in,
	input wire logic supply_good_flag_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_out,
	output logic sda_oe_out,
	output logic system_reset_n_out,
	output logic decode_window_enable_out,
	output logic dcdc_enable_out,
	output logic dac_cfg_error_out,
	output logic powered_out
);
	// ============================================================
	// pin synchronisers: switch and supply-good come from outside
	logic [1:0] sw_sync_reg;
	logic [1:0] pg_sync_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			sw_sync_reg <= 2'b00;
			pg_sync_reg <= 2'b00;
		end else begin
			sw_sync_reg <= {sw_sync_reg[0], on_switch_in};
			pg_sync_reg <= {pg_sync_reg[0], supply_good_flag_in};
		end
	end
	wire sw_on = sw_sync_reg[1];
	wire pg_ok = pg_sync_reg[1];

	// ============================================================
	// self-generated power-up reset counter
	logic [4:0] por_reg;
	wire por_done = (por_reg == 5'(pps_pkg::POR_CYC));
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) por_reg <= '0;
		else if (!por_done) por_reg <= por_reg + 5'h01;
	end

	// ============================================================
	// stability filter: any dropout restarts the count
	logic [31:0] stab_reg;
	wire stable = (stab_reg >= STABLE_CYC);
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || !pg_ok) stab_reg <= '0;
		else if (!stable) stab_reg <= stab_reg + 32'h1;
	end

	// ============================================================
	// i2c master
	pps_i2c_if rq ();
	pps_i2c_master u_i2c (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.rq(rq),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_oe_out(scl_oe_out),
		.sda_oe_out(sda_oe_out)
	);

	// ============================================================
	// sequencer
	pps_pkg::pps_state_t state_reg, state_next;
	logic req_sent_reg, req_sent_next;
	logic err_reg, err_next;
	wire shutdown = !sw_on || !pg_ok;

	always_comb begin
		state_next = state_reg;
		req_sent_next = req_sent_reg;
		err_next = err_reg;
		case (state_reg)
			pps_pkg::PPS_POR: if (por_done) state_next = pps_pkg::PPS_WAIT_PWR;
			pps_pkg::PPS_WAIT_PWR: begin
				if (stable && sw_on) begin
					state_next = pps_pkg::PPS_CFG_DAC;
					req_sent_next = 1'b0;
				end
			end
			pps_pkg::PPS_CFG_DAC: begin
				if (!req_sent_reg) req_sent_next = 1'b1;
				else if (rq.done) begin
					err_next = rq.nack;
					state_next = shutdown ? pps_pkg::PPS_DEC_OFF : pps_pkg::PPS_RUN;
				end
			end
			pps_pkg::PPS_RUN: if (shutdown) state_next = pps_pkg::PPS_DEC_OFF;
			pps_pkg::PPS_DEC_OFF: begin
				state_next = pps_pkg::PPS_DAC_LOW;
				req_sent_next = 1'b0;
			end
			pps_pkg::PPS_DAC_LOW: begin
				if (!req_sent_reg) req_sent_next = 1'b1;
				else if (rq.done) begin
					err_next = err_reg | rq.nack;
					state_next = pps_pkg::PPS_CUT_PWR;
				end
			end
			pps_pkg::PPS_CUT_PWR: state_next = pps_pkg::PPS_OFF;
			pps_pkg::PPS_OFF: state_next = pps_pkg::PPS_OFF; // only a new reset restarts
			default: state_next = pps_pkg::PPS_POR;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			state_reg <= pps_pkg::PPS_POR;
			req_sent_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_sent_reg <= req_sent_next;
			err_reg <= err_next;
		end
	end

	// ============================================================
	// i2c request: one-cycle pulse on entry to each write step
	wire in_cfg = (state_reg == pps_pkg::PPS_CFG_DAC);
	wire in_low = (state_reg == pps_pkg::PPS_DAC_LOW);
	assign rq.req = (in_cfg || in_low) && !req_sent_reg;
	assign rq.subaddr = in_low ? pps_pkg::DAC_GEN_CFG_SUBADDR : pps_pkg::DAC_FMT_SUBADDR;
	// power-down bit set on top of the base configuration
	assign rq.data = in_low
		? (pps_pkg::DAC_GEN_CFG_BASE | (8'h01 << pps_pkg::DAC_PWR_DOWN_BIT))
		: pps_pkg::DAC_FMT_VALUE;

	// ============================================================
	// output flops: converter and decoder enables kept separate
	logic sys_rst_n_reg;
	logic dec_en_reg;
	logic dcdc_en_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			sys_rst_n_reg <= 1'b0;
			dec_en_reg <= 1'b0;
			dcdc_en_reg <= 1'b1; // battery power held on while we sequence
		end else begin
			// dac kept out of reset until its low-power write is done
			sys_rst_n_reg <= (state_next == pps_pkg::PPS_CFG_DAC)
				|| (state_next == pps_pkg::PPS_RUN)
				|| (state_next == pps_pkg::PPS_DEC_OFF)
				|| (state_next == pps_pkg::PPS_DAC_LOW);
			dec_en_reg <= (state_next == pps_pkg::PPS_RUN);
			dcdc_en_reg <= (state_next != pps_pkg::PPS_OFF);
		end
	end
	assign system_reset_n_out = sys_rst_n_reg;
	assign decode_window_enable_out = dec_en_reg;
	assign dcdc_enable_out = dcdc_en_reg;
	assign dac_cfg_error_out = err_reg;
	assign powered_out = (state_reg == pps_pkg::PPS_RUN);
endmodule

// ---- test/pps_sequencer_monitor.sv ----
// pps_sequencer_monitor: port assertions for the power sequencer
`timescale 1ns/1ps
module pps_sequencer_monitor (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic on_switch_in,
	input wire logic supply_good_flag_in,
	input wire logic scl_oe_out,
	input wire logic sda_oe_out,
	input wire logic system_reset_n_out,
	input wire logic decode_window_enable_out,
	input wire logic dcdc_enable_out,
	input wire logic powered_out
);
	// ==========
	// one clock domain, so shared clocking and disable
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	a_rst_until_good: assert property (
		$rose(system_reset_n_out) |-> $past(supply_good_flag_in, 5)
		&& $past(supply_good_flag_in, 15)) else $error("reset released early");
	a_no_i2c_held: assert property (
		!system_reset_n_out && dcdc_enable_out |-> !scl_oe_out && !sda_oe_out)
		else $error("i2c active in reset");
	a_dec_needs_pwr: assert property (
		decode_window_enable_out |-> system_reset_n_out && dcdc_enable_out)
		else $error("decoder on without power");
	a_loss_stops_dec: assert property (
		powered_out && !(on_switch_in && supply_good_flag_in)
		|-> ##[1:4] !decode_window_enable_out) else $error("no shutdown");
	a_dec_off_first: assert property (
		$fell(decode_window_enable_out) |-> dcdc_enable_out[*8])
		else $error("converter cut with decoder");
	a_cut_last: assert property (
		$fell(dcdc_enable_out) |-> !decode_window_enable_out && !scl_oe_out && !sda_oe_out)
		else $error("converter cut too early");
	a_start_then_clk: assert property (
		$rose(sda_oe_out) && !scl_oe_out |-> ##[1:640] scl_oe_out)
		else $error("start without clock");
	a_scl_low_held: assert property (
		$rose(scl_oe_out) |=> scl_oe_out[*8]) else $error("scl low too short");
	a_off_stays: assert property (
		!dcdc_enable_out |=> !dcdc_enable_out && !powered_out) else $error("left off state");
	// main scenarios
	c_pwr_up: cover property ($rose(system_reset_n_out));
	c_dec_off: cover property ($fell(decode_window_enable_out));
	c_cut: cover property ($fell(dcdc_enable_out));
endmodule
bind pps_sequencer pps_sequencer_monitor u_pps_sequencer_monitor (.sys_clk_in, .reset_n_in,
	.on_switch_in, .supply_good_flag_in, .scl_oe_out, .sda_oe_out, .system_reset_n_out,
	.decode_window_enable_out, .dcdc_enable_out, .powered_out);

// ---- test/pps_dac_model.sv ----
// pps_dac_model: i2c target that acks and keeps the last 3-byte write
`timescale 1ns/1ps
module pps_dac_model (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	output logic ack_oe_out,
	output logic [23:0] frame_out,
	output int frames_out
);
	int n = 0;
	logic [23:0] sh;
	initial begin
		ack_oe_out = 0;
		frames_out = 0;
		frame_out = '0;
	end
	// start and stop are sda edges while scl is high
	always @(negedge sda_in) begin
		if (scl_in === 1'b1) n = 0;
	end
	always @(posedge sda_in) begin
		// 27 bit slots, then one more scl rise just ahead of the stop
		if (scl_in === 1'b1 && n == 28) begin
			frame_out = sh;
			frames_out++;
		end
	end
	// data shifts on rising scl; ack slots skipped
	always @(posedge scl_in) begin
		if (n < 27 && n % 9 != 8) sh = {sh[22:0], sda_in};
		n++;
	end
	// hold sda low through each ninth slot
	// nack_in refuses the data byte only, so the frame still completes
	always @(negedge scl_in) ack_oe_out <= (n % 9 == 8) && !(nack_in && n == 26);
endmodule

// ---- test/tb_player_power_sequencer.sv ----
// tb_player_power_sequencer: power on, config, shutdown of the sequencer
`timescale 1ns/1ps
module tb_player_power_sequencer;
	logic sys_clk_in, reset_n_in, on_sw, sup_good, scl_oe, sda_oe, ack_oe, scl, sda;
	logic rst_n, dec_en, dcdc_en, err, pwr, nak;
	logic [23:0] frame;
	logic [31:0] seed = 32'hb073;
	logic [31:0] r;
	int frames, i;
	int failures = 0;
	int total_checks = 0;
	// ==========
	// open-drain lines with pull-ups
	assign scl = !scl_oe;
	assign sda = !(sda_oe || ack_oe);
	pps_sequencer #(.STABLE_CYC(20)) u_pps_sequencer (.sys_clk_in, .reset_n_in,
		.on_switch_in(on_sw), .supply_good_flag_in(sup_good), .scl_in(scl), .sda_in(sda),
		.scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .system_reset_n_out(rst_n),
		.decode_window_enable_out(dec_en), .dcdc_enable_out(dcdc_en),
		.dac_cfg_error_out(err), .powered_out(pwr));
	pps_dac_model u_pps_dac_model (.scl_in(scl), .sda_in(sda), .nack_in(nak), .ack_oe_out(ack_oe),
		.frame_out(frame), .frames_out(frames));
	initial begin
		sys_clk_in = 0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected dac write: address with write bit, sub-address, data
	function automatic logic [23:0] dac_wr(logic [7:0] sub, logic [7:0] val);
		return {pps_pkg::DAC_ADDR, 1'b0, sub, val};
	endfunction
	task automatic chk(logic [23:0] got, logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// ==========
	// one power cycle; i2c at 100 kHz dominates the run
	initial begin
		reset_n_in = 0;
		on_sw = 1;
		nak = 0;
		sup_good = 0;
		cyc(10);
		reset_n_in = 1;
		// chattering supply never gives a clean stretch
		for (int k = 0; k < 60; k++) begin
			r = rnd();
			sup_good = r[0] && (k % 8 != 7);
			cyc(1);
		end
		chk(24'({rst_n, dec_en, dcdc_en, sda_oe, scl_oe}), 24'h4);
		$display("test chatter hold done");
		sup_good = 1;
		for (i = 0; i < 100 && rst_n !== 1'b1; i++) cyc(1);
		chk(24'({rst_n, dec_en, pwr}), 24'h4);
		// reset in mid-write: lines let go, the half frame never counts
		cyc(2000);
		reset_n_in = 0;
		cyc(10);
		chk(24'({rst_n, dec_en, dcdc_en, sda_oe, scl_oe}), 24'h4);
		chk(24'(frames), 24'h0);
		reset_n_in = 1;
		r = rnd();
		nak = r[0]; // random refusal of the data byte
		for (i = 0; i < 100 && rst_n !== 1'b1; i++) cyc(1);
		chk(24'({rst_n, dec_en, pwr}), 24'h4);
		$display("test mid-write reset done");
		for (i = 0; i < 40000 && pwr !== 1'b1; i++) cyc(1);
		chk(frame, dac_wr(pps_pkg::DAC_FMT_SUBADDR, pps_pkg::DAC_FMT_VALUE));
		chk(24'(frames), 24'h1);
		chk(24'({rst_n, dec_en, dcdc_en, err}), 24'({3'h7, nak}));
		$display("test power on done");
		r = rnd();
		cyc(int'(r[3:0]) + 2);
		// random choice of switch off or supply loss
		if (r[4]) on_sw = 0;
		else sup_good = 0;
		cyc(6);
		chk(24'({pwr, dec_en, dcdc_en}), 24'h1);
		for (i = 0; i < 40000 && dcdc_en !== 1'b0; i++) cyc(1);
		chk(frame, dac_wr(pps_pkg::DAC_GEN_CFG_SUBADDR, pps_pkg::DAC_GEN_CFG_BASE
			| 8'(1 << pps_pkg::DAC_PWR_DOWN_BIT)));
		chk(24'(frames), 24'h2);
		on_sw = 1;
		sup_good = 1;
		cyc(50);
		chk(24'({dcdc_en, dec_en, pwr, sda_oe, scl_oe, rst_n}), 24'h0);
		$display("test power down done");
		stop_test();
	end
	// watchdog well beyond two i2c writes
	initial begin
		cyc(95000);
		failures++;
		stop_test();
	end
endmodule
